// ### tb/cor_err_status_checker.sv
// assertion checker for the correctable error status bank
`timescale 1ns/10ps
module cor_err_status_checker (
  input wire logic        aclk,                       // clock
  input wire logic        aresetn,                    // reset, low
  input wire logic        port_reset_n,               // port reset, low
  input wire logic        awvalid,                    // aw valid
  input wire logic        awready,                    // aw ready
  input wire logic        wvalid,                     // w valid
  input wire logic        wready,                     // w ready
  input wire logic        bvalid,                     // b valid
  input wire logic        bready,                     // b ready
  input wire logic        arvalid,                    // ar valid
  input wire logic        arready,                    // ar ready
  input wire logic [31:0] rdata,                      // read data
  input wire logic [1:0]  rresp,                      // read code
  input wire logic        rvalid,                     // r valid
  input wire logic        rready,                     // r ready
  input wire logic [31:0] uncorrectable_error_status, // uncorrectable flags
  input wire logic [4:0]  first_error_pointer,        // pointer
  input wire logic        cor_err_report,             // report pulse
  input wire logic        header_log_locked           // pointer valid
);
  logic                   fep_bit;                    // selected uncorrectable flag
  assign fep_bit = uncorrectable_error_status[first_error_pointer];
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ********************************************************************
  // bus handshakes
  // ********************************************************************
  // answers must stand until taken, or the master loses them
  ar_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer missing");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  b_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped");
  ar_block_a: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  aw_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  w_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  err_zero_a: assert property (rvalid && rresp == cor_err_pkg::RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read carries data");
  // ********************************************************************
  // pointer and reporting
  // ********************************************************************
  lock_track_a: assert property (
    $past(aresetn) |-> header_log_locked == $past(fep_bit))
    else $error("pointer valid flag wrong");
  port_rst_a: assert property (!port_reset_n |=> !cor_err_report)
    else $error("report during port reset");
endmodule
bind cor_err_status cor_err_status_checker cor_err_status_checker_inst (
  .aclk, .aresetn, .port_reset_n, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
  .uncorrectable_error_status, .first_error_pointer, .cor_err_report,
  .header_log_locked);

// ### tb/cor_err_status_tb.sv
// self-checking testbench for the correctable error status bank
`timescale 1ns/10ps
module cor_err_status_tb;
  logic         aclk = 1'b0, aresetn = 1'b0, port_reset_n = 1'b1;
  logic [11:0]  awaddr = 12'h0, araddr = 12'h0;
  logic [31:0]  wdata = 32'h0, ues = 32'h0, rdata, st = 32'h0, d, v;
  logic [31:0]  mk = cor_err_pkg::MASK_RESET;
  logic [3:0]   wstrb = 4'hf;
  logic [1:0]   bresp, rresp, r;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [6:0]   ev = 7'h0;
  logic         header_log_req = 1'b0, cor_err_report, cor_err_pending, header_log_locked;
  logic [127:0] header_in = 128'h0;
  logic [4:0]   fep = 5'h0;
  int           num_errors = 0, checked = 0, cyc = 0, seed = 43, i, k;
  int           pos [7] = '{0, 6, 7, 8, 12, 13, 14};

  cor_err_status cor_err_status_inst (
    .aclk, .aresetn, .port_reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .receiver_error(ev[0]), .bad_packet(ev[1]),
    .bad_link_packet(ev[2]), .replay_rollover(ev[3]), .replay_timeout(ev[4]),
    .advisory_nonfatal(ev[5]), .internal_correctable(ev[6]), .header_log_req,
    .header_in, .uncorrectable_error_status(ues), .first_error_pointer(fep),
    .cor_err_report, .cor_err_pending, .header_log_locked);

  // ********************************************************************
  // clock, hang guard and helpers
  // ********************************************************************
  initial begin
    forever #5 aclk = ~aclk;
  end
  // generous ceiling, the full run needs a few hundred cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // event vector to status bit positions
  function automatic logic [31:0] map(input logic [6:0] e);
    map = 32'h0;
    for (int j = 0; j < 7; j++)
      map[pos[j]] = e[j];
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // ready is sampled at the falling edge, where it has settled
  task wr(input logic [11:0] a, input logic [31:0] w, input logic [1:0] e);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= w;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    chk(r, e);
    @(posedge aclk);
  endtask
  task rd(input logic [11:0] a);
    logic ta, tv;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tv);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
    chk(r, cor_err_pkg::RESP_OKAY);
  endtask
  // one-cycle event burst, then report and pending against the model
  task pulse(input logic [6:0] e);
    ev <= e;
    @(posedge aclk);
    ev <= 7'h0;
    #1;
    st = st | map(e);
    chk(cor_err_report, |(map(e) & ~mk));
    @(posedge aclk);
    #1;
    chk(cor_err_pending, |(st & ~mk));
    @(posedge aclk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(cor_err_pkg::STATUS_OFFSET, 32'h0);
    rc(cor_err_pkg::MASK_OFFSET, mk);
    $display("reset test done");
    // each source alone: zero write kept, one write clears
    for (i = 0; i < 7; i++) begin
      pulse(7'h1 << i);
      rc(cor_err_pkg::STATUS_OFFSET, st);
      wr(cor_err_pkg::STATUS_OFFSET, 32'h0, cor_err_pkg::RESP_OKAY);
      rc(cor_err_pkg::STATUS_OFFSET, st);
      wr(cor_err_pkg::STATUS_OFFSET, st, cor_err_pkg::RESP_OKAY);
      st = 32'h0;
      rc(cor_err_pkg::STATUS_OFFSET, st);
    end
    $display("event test done");
    // reserved writes change nothing; port reset leaves flags alone
    pulse(7'h7f);
    wr(cor_err_pkg::STATUS_OFFSET, ~cor_err_pkg::DEFINED_BITS, cor_err_pkg::RESP_OKAY);
    // an unmasked event under port reset must not be reported
    port_reset_n <= 1'b0;
    ev <= 7'h01;
    @(posedge aclk);
    port_reset_n <= 1'b1;
    ev <= 7'h00;
    #1;
    chk(cor_err_report, 1'b0);
    @(posedge aclk);
    rc(cor_err_pkg::STATUS_OFFSET, st);
    $display("reserved and sticky test done");
    // pointer valid: header refused and overflow flagged
    ues <= 32'h8;
    fep <= 5'h3;
    header_in <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    repeat (2) @(posedge aclk);
    #1;
    chk(header_log_locked, 1'b1);
    @(posedge aclk);
    header_log_req <= 1'b1;
    @(posedge aclk);
    header_log_req <= 1'b0;
    st[15] = 1'b1;
    rc(cor_err_pkg::STATUS_OFFSET, st);
    rc(cor_err_pkg::HDR0_OFFSET, 32'h0);
    // selected bit cleared: pointer invalid, header captured
    ues <= 32'hfffffff7;
    repeat (2) @(posedge aclk);
    #1;
    chk(header_log_locked, 1'b0);
    @(posedge aclk);
    header_log_req <= 1'b1;
    @(posedge aclk);
    header_log_req <= 1'b0;
    for (k = 0; k < 4; k++)
      rc(cor_err_pkg::HDR0_OFFSET + 12'(4 * k), header_in[32 * k +: 32]);
    rc(cor_err_pkg::STATUS_OFFSET, st);
    $display("header log test done");
    // random mask, random event bursts
    v = $random(seed);
    wstrb <= 4'($random(seed));
    wr(cor_err_pkg::MASK_OFFSET, v, cor_err_pkg::RESP_OKAY);
    for (k = 0; k < 4; k++)
      if (wstrb[k]) mk[8 * k +: 8] = v[8 * k +: 8];
    mk = mk & cor_err_pkg::DEFINED_BITS;
    wstrb <= 4'hf;
    rc(cor_err_pkg::MASK_OFFSET, mk);
    wr(cor_err_pkg::STATUS_OFFSET, 32'hffffffff, cor_err_pkg::RESP_OKAY);
    st = 32'h0;
    for (i = 0; i < 40; i++)
      pulse(7'($random(seed)));
    rc(cor_err_pkg::STATUS_OFFSET, st);
    $display("random test done");
    // unmapped address answers with an error and no data
    rd(12'h200);
    chk(d, 32'h0);
    chk(r, cor_err_pkg::RESP_SLVERR);
    wr(12'h200, 32'hffffffff, cor_err_pkg::RESP_SLVERR);
    // header words answer writes but keep the logged header
    wr(cor_err_pkg::HDR0_OFFSET, ~header_in[31:0], cor_err_pkg::RESP_OKAY);
    rc(cor_err_pkg::HDR0_OFFSET, header_in[31:0]);
    $display("unmapped test done");
    wrap_up();
  end
endmodule

// ### verilog/cor_err_pkg.sv
// constants shared by the correctable error status block
package cor_err_pkg;

  // ********************************************************************
  // register offsets (byte addresses)
  // ********************************************************************
  localparam logic [11:0] STATUS_OFFSET = 12'h110;
  localparam logic [11:0] MASK_OFFSET   = 12'h114;
  localparam logic [11:0] HDR0_OFFSET   = 12'h11c;
  localparam logic [11:0] HDR1_OFFSET   = 12'h120;
  localparam logic [11:0] HDR2_OFFSET   = 12'h124;
  localparam logic [11:0] HDR3_OFFSET   = 12'h128;

  // ********************************************************************
  // status field positions
  // ********************************************************************
  localparam int RECEIVER_ERROR_POS     = 0;
  localparam int BAD_PACKET_POS         = 6;
  localparam int BAD_LINK_PACKET_POS    = 7;
  localparam int REPLAY_ROLLOVER_POS    = 8;
  localparam int REPLAY_TIMEOUT_POS     = 12;
  localparam int ADVISORY_NONFATAL_POS  = 13;
  localparam int INTERNAL_CORR_POS      = 14;
  localparam int HEADER_LOG_OVF_POS     = 15;

  // ********************************************************************
  // implemented bits and reset values
  // ********************************************************************
  localparam logic [31:0] DEFINED_BITS  = 32'h0000_f1c1;
  localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET    = 32'h0000_e000;
  localparam logic [31:0] HDR_RESET     = 32'h0000_0000;

  // ********************************************************************
  // bus answers
  // ********************************************************************
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// ### verilog/cor_err_status.sv
// correctable error status register bank with axi4-lite slave
//
// Overview of operation
// - receiver error sets status bit 0
// - bad packet sets status bit 6
// - bad link packet sets status bit 7
// - replay rollover sets status bit 8
// - replay timer expiry sets status bit 12
// - advisory non-fatal error sets bit 13
// - port internal correctable error sets bit 14
// - unloggable header sets overflow bit 15
// - valid pointer blocks header log overwrite
// - pointer valid while selected uncorrectable bit set
// - mask stops report, status still recorded
`timescale 1ns/10ps
module cor_err_status (
  input  wire logic         aclk,                 // core clock, 100 MHz
  input  wire logic         aresetn,              // power-on reset, sync, low
  input  wire logic         port_reset_n,         // non-sticky port reset, low
  // axi4-lite write address
  input  wire logic [11:0]  awaddr,               // write byte address
  input  wire logic         awvalid,              // write address valid
  output logic              awready,              // write address ready
  // axi4-lite write data
  input  wire logic [31:0]  wdata,                // write data
  input  wire logic [3:0]   wstrb,                // byte lane strobes
  input  wire logic         wvalid,               // write data valid
  output logic              wready,               // write data ready
  // axi4-lite write response
  output logic [1:0]        bresp,                // write answer code
  output logic              bvalid,               // write answer valid
  input  wire logic         bready,               // write answer ready
  // axi4-lite read address
  input  wire logic [11:0]  araddr,               // read byte address
  input  wire logic         arvalid,              // read address valid
  output logic              arready,              // read address ready
  // axi4-lite read data
  output logic [31:0]       rdata,                // read data
  output logic [1:0]        rresp,                // read answer code
  output logic              rvalid,               // read data valid
  input  wire logic         rready,               // read data ready
  // error events from the port, one-cycle pulses
  input  wire logic         receiver_error,       // physical layer error
  input  wire logic         bad_packet,           // bad transaction packet
  input  wire logic         bad_link_packet,      // bad link layer packet
  input  wire logic         replay_rollover,      // replay number rolled over
  input  wire logic         replay_timeout,       // replay timer expired
  input  wire logic         advisory_nonfatal,    // advisory non-fatal error
  input  wire logic         internal_correctable, // port internal error
  // header logging
  input  wire logic         header_log_req,       // error needs header logged
  input  wire logic [127:0] header_in,            // header, word 0 in low bits
  input  wire logic [31:0]  uncorrectable_error_status, // uncorrectable flags
  input  wire logic [4:0]   first_error_pointer,  // selects uncorrectable bit
  // reporting
  output logic              cor_err_report,       // one-cycle unmasked report
  output logic              cor_err_pending,      // unmasked flag still set
  output logic              header_log_locked     // pointer currently valid
);

  // ********************************************************************
  // declarations
  // ********************************************************************
  flag_bank_if      status_bus ();
  logic             aw_held;
  logic [11:0]      aw_addr_q;
  logic             w_held;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             do_write;
  logic [31:0]      lane_mask;
  logic [31:0]      correctable_error_mask;
  logic [31:0]      header_log_words [4];
  logic [31:0]      event_vec;
  logic             fep_valid;
  logic             write_hit;
  logic [31:0]      next_rdata;
  logic [1:0]       next_rresp;
  logic             capture_header;
  logic             log_overflow;
  logic             status_wr;
  logic             mask_wr;
  logic [31:0]      unmasked_events;
  logic [31:0]      unmasked_flags;
  logic [5:0]       rd_sel;
  logic [1:0]       next_bresp;

  // ********************************************************************
  // sticky flag bank
  // ********************************************************************
  // flags live on aresetn only, so a port reset leaves them alone
  // and software can still read what happened before the port reset
  sticky_flags #(
    .DEFINED (cor_err_pkg::DEFINED_BITS)
  ) sticky_flags_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fb      (status_bus.owner)
  );

  // ********************************************************************
  // first error pointer and header logging
  // ********************************************************************
  // the pointer only counts while the flag it selects is still set;
  // the pointer itself is held in the control register outside this bank
  assign fep_valid = uncorrectable_error_status[first_error_pointer];

  // a request while the pointer is valid overflows instead of logging,
  // so the first error's header is never lost to a later one
  assign capture_header = header_log_req && !fep_valid;
  assign log_overflow   = header_log_req && fep_valid;

  // capture a header only when no earlier uncorrectable error holds it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        header_log_words[i] <= cor_err_pkg::HDR_RESET;
      end
    end else if (capture_header) begin
      for (int i = 0; i < 4; i++) begin
        header_log_words[i] <= header_in[i*32 +: 32];
      end
    end
  end

  // lock state is shown registered for firmware visibility
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      header_log_locked <= 1'b0;
    end else begin
      header_log_locked <= fep_valid;
    end
  end

  // ********************************************************************
  // event collection
  // ********************************************************************
  // each event lands on its own status position;
  // a level held for several cycles keeps its flag set and, while unmasked, keeps cor_err_report high
  always_comb begin
    event_vec = 32'h0000_0000;
    event_vec[cor_err_pkg::RECEIVER_ERROR_POS]    = receiver_error;
    event_vec[cor_err_pkg::BAD_PACKET_POS]        = bad_packet;
    event_vec[cor_err_pkg::BAD_LINK_PACKET_POS]   = bad_link_packet;
    event_vec[cor_err_pkg::REPLAY_ROLLOVER_POS]   = replay_rollover;
    event_vec[cor_err_pkg::REPLAY_TIMEOUT_POS]    = replay_timeout;
    event_vec[cor_err_pkg::ADVISORY_NONFATAL_POS] = advisory_nonfatal;
    event_vec[cor_err_pkg::INTERNAL_CORR_POS]     = internal_correctable;
    // header could not be logged because the log is held
    event_vec[cor_err_pkg::HEADER_LOG_OVF_POS]    = log_overflow;
  end

  assign status_bus.set = event_vec;

  // ********************************************************************
  // reporting to the root complex
  // ********************************************************************
  // events and flags that survive the mask
  assign unmasked_events = event_vec & ~correctable_error_mask;
  assign unmasked_flags  = status_bus.q & ~correctable_error_mask;

  // masking gates the report and the pending summary; the flag is still recorded;
  // a port reset drops a report in flight and leaves the flags alone
  always_ff @(posedge aclk) begin
    if (!aresetn || !port_reset_n) begin
      cor_err_report <= 1'b0;
    end else begin
      cor_err_report <= |unmasked_events;
    end
  end

  // level summary of flags that are not masked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cor_err_pending <= 1'b0;
    end else begin
      cor_err_pending <= |unmasked_flags;
    end
  end

  // ********************************************************************
  // axi4-lite write channels
  // ********************************************************************
  // address and data are taken in either order and held until the
  // write is done; new ones are refused while a response waits
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign status_wr = do_write && (aw_addr_q == cor_err_pkg::STATUS_OFFSET);
  assign mask_wr   = do_write && (aw_addr_q == cor_err_pkg::MASK_OFFSET);

  // write address holding register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (awvalid && awready) begin
      aw_held   <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (do_write) begin
      aw_held   <= 1'b0;
    end
  end

  // write data holding register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_held  <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (do_write) begin
      w_held  <= 1'b0;
    end
  end

  // byte strobes widened to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_mask[i*8 +: 8] = {8{wstrb_q[i]}};
    end
  end

  // decode of writable or read-only mapped words
  always_comb begin
    case (aw_addr_q)
      cor_err_pkg::STATUS_OFFSET: write_hit = 1'b1;
      cor_err_pkg::MASK_OFFSET:   write_hit = 1'b1;
      cor_err_pkg::HDR0_OFFSET:   write_hit = 1'b1;
      cor_err_pkg::HDR1_OFFSET:   write_hit = 1'b1;
      cor_err_pkg::HDR2_OFFSET:   write_hit = 1'b1;
      cor_err_pkg::HDR3_OFFSET:   write_hit = 1'b1;
      default:                    write_hit = 1'b0;
    endcase
  end

  // ones written to status clear; zeros and reserved bits do nothing
  always_comb begin
    if (status_wr) begin
      status_bus.clr = wdata_q & lane_mask & cor_err_pkg::DEFINED_BITS;
    end else begin
      status_bus.clr = 32'h0000_0000;
    end
  end

  // mask register, only defined bits are writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      correctable_error_mask <= cor_err_pkg::MASK_RESET;
    end else if (mask_wr) begin
      correctable_error_mask <= ((correctable_error_mask & ~lane_mask) |
                                 (wdata_q & lane_mask)) & cor_err_pkg::DEFINED_BITS;
    end
  end

  // unmapped words answer with an error and change nothing;
  // the master still gets an answer, so it never waits forever
  always_comb begin
    if (write_hit) begin
      next_bresp = cor_err_pkg::RESP_OKAY;
    end else begin
      next_bresp = cor_err_pkg::RESP_SLVERR;
    end
  end

  // write response; header log words accept writes but ignore them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= cor_err_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= next_bresp;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // ********************************************************************
  // axi4-lite read channels
  // ********************************************************************
  // one read in flight; a new address waits until the data is taken
  assign arready = !rvalid;

  // ********************************************************************
  // read address decode
  // ********************************************************************
  // one-hot select of the word being read; all zero means unmapped,
  // decoded once so the data mux and the answer code cannot disagree
  always_comb begin
    rd_sel = 6'h00;
    case (araddr)
      cor_err_pkg::STATUS_OFFSET: rd_sel[0] = 1'b1;
      cor_err_pkg::MASK_OFFSET:   rd_sel[1] = 1'b1;
      cor_err_pkg::HDR0_OFFSET:   rd_sel[2] = 1'b1;
      cor_err_pkg::HDR1_OFFSET:   rd_sel[3] = 1'b1;
      cor_err_pkg::HDR2_OFFSET:   rd_sel[4] = 1'b1;
      cor_err_pkg::HDR3_OFFSET:   rd_sel[5] = 1'b1;
      default:                    rd_sel    = 6'h00;
    endcase
  end

  // read data of the selected word; reserved positions come back as zero
  always_comb begin
    next_rresp = cor_err_pkg::RESP_OKAY;
    next_rdata = 32'h0000_0000;
    if (rd_sel[0]) begin
      next_rdata = status_bus.q;
    end else if (rd_sel[1]) begin
      next_rdata = correctable_error_mask;
    end else if (rd_sel[2]) begin
      next_rdata = header_log_words[0];
    end else if (rd_sel[3]) begin
      next_rdata = header_log_words[1];
    end else if (rd_sel[4]) begin
      next_rdata = header_log_words[2];
    end else if (rd_sel[5]) begin
      next_rdata = header_log_words[3];
    end else begin
      next_rresp = cor_err_pkg::RESP_SLVERR;
    end
  end

  // read data register, loaded at the address handshake;
  // registered so the data stand unchanged until the master takes them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= cor_err_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// ### verilog/flag_bank_if.sv
// interface between the register front end and the sticky flag bank
`timescale 1ns/10ps
interface flag_bank_if;
  logic [31:0] set;  // hardware events, one cycle each
  logic [31:0] clr;  // software write-one clears
  logic [31:0] q;    // present flag values

  modport owner (input set, input clr, output q);
  modport user  (output set, output clr, input q);
endinterface

// ### verilog/sticky_flags.sv
// bank of write-one-to-clear sticky flags
`timescale 1ns/10ps
module sticky_flags #(
  parameter logic [31:0] DEFINED = 32'h0000_0000
) (
  input wire logic    aclk,    // core clock
  input wire logic    aresetn, // power-on reset, sync, low
  flag_bank_if.owner  fb       // set, clear and value
);

  // ********************************************************************
  // flag storage
  // ********************************************************************
  // a set in the same cycle as its clear wins, so no event is lost;
  // undefined positions never hold a one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb.q <= cor_err_pkg::STATUS_RESET;
    end else begin
      fb.q <= ((fb.q & ~fb.clr) | fb.set) & DEFINED;
    end
  end

endmodule
